// ===== verilog/cpu_bus_end.sv
`timescale 1ns/100ps
`include "bus_cycle_defines.svh"
// Contract
// - Processor clock is core clock halved.
// - Reset falling edge aligns divide-by-two phase.
// - Read cycles receive data, writes drive it.
// - Hold floats data, last level kept; after a read the lines show the processor's last output value instead.
// - Address out; upper eight low for I/O.
// - Hold floats address and upper byte enable.
// - Upper enable and A0 encode byte lanes.
// - Upper-byte devices gate selects with enable.
// - Either status low marks status state.
// - Hold floats both status lines high.
// - Interrupt acknowledge is select 0,0 status 00.
// - Status 00 memory side: A1 halt, else shutdown.
// - Memory data read 01, write 10.
// - Status 11 means no status cycle.
// - I/O read 01, write 10.
// - Memory select high memory/halt, low I/O/acknowledge.
// - Cycle extends until ready is sampled low.
// - Hold: float first, then grant until released.

module cpu_bus_end
    import bus_cycle_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    input  wire logic               clk_en,
    local_bus_if.cpu                bus,
    input  wire logic               req_valid,
    input  cycle_kind_t             req_kind,
    input  lane_t                   req_lane,
    input  wire logic [`ADDR_W-1:0] req_addr,
    input  wire logic [`DATA_W-1:0] req_wdata,
    output logic                    req_busy,
    output logic                    req_done,
    output logic [`DATA_W-1:0]      req_rdata
);

    // Bus states, each lasting whole processor cycles
    typedef enum logic [2:0] {
        S_IDLE,   // Bus driven, no cycle
        S_STATUS, // Status lines low for one processor cycle
        S_CMD,    // Waiting for ready
        S_FLOAT,  // Drivers off, grant not yet given
        S_HOLD    // Bus granted to the other master
    } state_t;

    // Status code {cod, mio, s1_n, s0_n} for each cycle kind
    function automatic logic [3:0] status_code(input cycle_kind_t k);
        unique case (k)
            CYC_INTACK:   status_code = 4'h0;
            CYC_HALT:     status_code = 4'h4;
            CYC_SHUTDOWN: status_code = 4'h4;
            CYC_MEM_RD:   status_code = 4'h5;
            CYC_MEM_WR:   status_code = 4'h6;
            CYC_CODE_RD:  status_code = 4'hd;
            CYC_IO_RD:    status_code = 4'h9;
            CYC_IO_WR:    status_code = 4'ha;
        endcase
    endfunction

    // True for cycle kinds that drive the data lines
    function automatic logic is_write(input cycle_kind_t k);
        is_write = (k == CYC_MEM_WR) || (k == CYC_IO_WR);
    endfunction

    state_t             state_reg, state_next;
    logic               phase_reg, phase_next;   // High in second half
    logic [`ADDR_W-1:0] addr_reg, addr_next;
    logic               ube_n_reg, ube_n_next;
    logic               aoe_reg, aoe_next;       // Address drivers on
    logic               s1n_reg, s1n_next;
    logic               s0n_reg, s0n_next;
    logic               soe_reg, soe_next;       // Status drivers on
    logic               mio_reg, mio_next;
    logic               cod_reg, cod_next;
    logic [`DATA_W-1:0] dout_reg, dout_next;
    logic               doe_reg, doe_next;
    logic               grant_reg, grant_next;
    logic               busy_reg, busy_next;
    logic               done_reg, done_next;
    logic [`DATA_W-1:0] rdata_reg, rdata_next;
    cycle_kind_t        kind_reg, kind_next;
    logic               tick;                    // Processor cycle edge
    logic [3:0]         code;

    // A processor cycle ends on every second enabled core edge
    assign tick = phase_reg;
    assign code = status_code(req_kind);

    // Next values of the bus sequencer
    always_comb begin
        state_next = state_reg;
        phase_next = ~phase_reg;
        addr_next = addr_reg;
        ube_n_next = ube_n_reg;
        aoe_next = aoe_reg;
        s1n_next = s1n_reg;
        s0n_next = s0n_reg;
        soe_next = soe_reg;
        mio_next = mio_reg;
        cod_next = cod_reg;
        dout_next = dout_reg;
        doe_next = doe_reg;
        grant_next = grant_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        rdata_next = rdata_reg;
        kind_next = kind_reg;
        if (tick) begin
            unique case (state_reg)
                S_IDLE: begin
                    if (bus.hold_req) begin
                        // Drivers go off a full cycle before the grant
                        aoe_next = 1'b0;
                        soe_next = 1'b0;
                        s1n_next = 1'b1;
                        s0n_next = 1'b1;
                        doe_next = 1'b0;
                        state_next = S_FLOAT;
                    end else if (req_valid) begin
                        kind_next = req_kind;
                        {cod_next, mio_next} = code[3:2];
                        {s1n_next, s0n_next} = code[1:0];
                        addr_next = req_addr;
                        if (req_kind == CYC_IO_RD || req_kind == CYC_IO_WR)
                            addr_next[`ADDR_W-1:`IO_ZERO_LSB] = '0;
                        if (req_kind == CYC_HALT)
                            addr_next[`HALT_BIT] = 1'b1;
                        if (req_kind == CYC_SHUTDOWN)
                            addr_next[`HALT_BIT] = 1'b0;
                        // Lane code 1,1 cannot be formed here
                        unique case (req_lane)
                            LANE_LO: begin
                                ube_n_next = 1'b1;
                                addr_next[0] = 1'b0;
                            end
                            LANE_HI: begin
                                ube_n_next = 1'b0;
                                addr_next[0] = 1'b1;
                            end
                            default: begin
                                ube_n_next = 1'b0;
                                addr_next[0] = 1'b0;
                            end
                        endcase
                        dout_next = req_wdata;
                        busy_next = 1'b1;
                        state_next = S_STATUS;
                    end
                end
                S_STATUS: begin
                    // Status returns to 11 after one processor cycle
                    s1n_next = 1'b1;
                    s0n_next = 1'b1;
                    doe_next = is_write(kind_reg);
                    state_next = S_CMD;
                end
                S_CMD: begin
                    if (!bus.ready_n) begin
                        if (!is_write(kind_reg))
                            rdata_next = bus.data_bus;
                        doe_next = 1'b0;
                        busy_next = 1'b0;
                        done_next = 1'b1;
                        state_next = S_IDLE;
                    end
                end
                S_FLOAT: begin
                    grant_next = 1'b1;
                    state_next = S_HOLD;
                end
                S_HOLD: begin
                    // Ready is ignored while the bus is granted
                    if (!bus.hold_req) begin
                        grant_next = 1'b0;
                        aoe_next = 1'b1;
                        soe_next = 1'b1;
                        state_next = S_IDLE;
                    end
                end
                default: state_next = S_IDLE;
            endcase
        end
    end

    // Sequencer registers; held reset parks the divider at phase zero,
    // so its release edge aligns processor cycles on both ends
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= S_IDLE;
            phase_reg <= 1'b0;
            addr_reg <= '0;
            ube_n_reg <= 1'b1;
            aoe_reg <= 1'b1;
            s1n_reg <= 1'b1;
            s0n_reg <= 1'b1;
            soe_reg <= 1'b1;
            mio_reg <= 1'b1;
            cod_reg <= 1'b1;
            dout_reg <= '0;
            doe_reg <= 1'b0;
            grant_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            rdata_reg <= '0;
            kind_reg <= CYC_MEM_RD;
        end else if (clk_en) begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            addr_reg <= addr_next;
            ube_n_reg <= ube_n_next;
            aoe_reg <= aoe_next;
            s1n_reg <= s1n_next;
            s0n_reg <= s0n_next;
            soe_reg <= soe_next;
            mio_reg <= mio_next;
            cod_reg <= cod_next;
            dout_reg <= dout_next;
            doe_reg <= doe_next;
            grant_reg <= grant_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            rdata_reg <= rdata_next;
            kind_reg <= kind_next;
        end
    end

    // Pins come straight from the registers above
    assign bus.cpu_addr = addr_reg;
    assign bus.cpu_addr_oe = aoe_reg;
    assign bus.upper_byte_enable_n = ube_n_reg;
    assign bus.cycle_status_hi_n = s1n_reg;
    assign bus.cycle_status_lo_n = s0n_reg;
    assign bus.status_oe = soe_reg;
    assign bus.mem_io_select = mio_reg;
    assign bus.code_or_intack_select = cod_reg;
    assign bus.cpu_data_out = dout_reg;
    assign bus.cpu_data_oe = doe_reg;
    assign bus.hold_grant = grant_reg;
    assign bus.proc_phase = phase_reg;
    assign req_busy = busy_reg;
    assign req_done = done_reg;
    assign req_rdata = rdata_reg;

endmodule

// ===== verilog/bus_cycle_defines.svh
`ifndef BUS_CYCLE_DEFINES_SVH
`define BUS_CYCLE_DEFINES_SVH

// Width of the physical address outputs
`define ADDR_W 24
// Width of the data lines
`define DATA_W 16
// Lowest address bit forced low during I/O transfers
`define IO_ZERO_LSB 16
// Address bit that tells halt from shutdown
`define HALT_BIT 1
// Core clocks per processor cycle
`define CLK_DIV 2
// Default wait states added by the controller end
`define WAIT_DEFAULT 0

`endif

// ===== verilog/bus_cycle_pkg.sv
package bus_cycle_pkg;

    // Bus cycle kinds that the processor end can start
    typedef enum logic [2:0] {
        CYC_INTACK,
        CYC_HALT,
        CYC_SHUTDOWN,
        CYC_MEM_RD,
        CYC_MEM_WR,
        CYC_CODE_RD,
        CYC_IO_RD,
        CYC_IO_WR
    } cycle_kind_t;

    // Byte lanes of a transfer
    typedef enum logic [1:0] {
        LANE_WORD,
        LANE_LO,
        LANE_HI
    } lane_t;

endpackage

// ===== verilog/local_bus_if.sv
`timescale 1ns/100ps
`include "bus_cycle_defines.svh"

interface local_bus_if;
    logic [`ADDR_W-1:0] cpu_addr;      // Address driven by processor
    logic               cpu_addr_oe;   // Address and byte enable driven
    logic               upper_byte_enable_n;
    logic               cycle_status_hi_n;
    logic               cycle_status_lo_n;
    logic               status_oe;     // Status pins driven
    logic               mem_io_select;
    logic               code_or_intack_select;
    logic [`DATA_W-1:0] cpu_data_out;
    logic               cpu_data_oe;
    logic [`DATA_W-1:0] ctrl_data_out;
    logic               ctrl_data_oe;
    logic               ready_n;
    logic               hold_req;
    logic               hold_grant;
    logic               proc_phase;    // Processor clock phase
    logic [`DATA_W-1:0] data_bus;      // Resolved data lines
    logic               status_hi_bus; // Resolved status, pulled high
    logic               status_lo_bus;

    // Undriven data lines show the value last loaded into the processor's data output, read or write
    assign data_bus = cpu_data_oe ? cpu_data_out :
                      (ctrl_data_oe ? ctrl_data_out : cpu_data_out);
    // Floated status pins rest at logic one
    assign status_hi_bus = status_oe ? cycle_status_hi_n : 1'b1;
    assign status_lo_bus = status_oe ? cycle_status_lo_n : 1'b1;

    modport cpu (
        output cpu_addr, cpu_addr_oe, upper_byte_enable_n,
               cycle_status_hi_n, cycle_status_lo_n, status_oe,
               mem_io_select, code_or_intack_select,
               cpu_data_out, cpu_data_oe, hold_grant, proc_phase,
        input  data_bus, ready_n, hold_req
    );

    modport ctrl (
        output ctrl_data_out, ctrl_data_oe, ready_n, hold_req,
        input  cpu_addr, cpu_addr_oe, upper_byte_enable_n,
               status_hi_bus, status_lo_bus, mem_io_select,
               code_or_intack_select, data_bus, hold_grant, proc_phase
    );
endinterface

// ===== verilog/bus_ctrl_end.sv
`timescale 1ns/100ps
`include "bus_cycle_defines.svh"

module bus_ctrl_end
    import bus_cycle_pkg::*;
#(
    parameter int WAIT_STATES = `WAIT_DEFAULT
) (
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    input  wire logic               clk_en,
    local_bus_if.ctrl               bus,
    input  wire logic               hold_request,
    input  wire logic [`DATA_W-1:0] read_data,
    output logic                    cyc_valid,
    output cycle_kind_t             cyc_kind,
    output logic [`ADDR_W-1:0]      cyc_addr,
    output logic [`DATA_W-1:0]      cyc_wdata,
    output logic                    upper_lane_sel,
    output logic                    hold_granted
);

    typedef enum logic [1:0] {C_IDLE, C_WAIT, C_END} cstate_t;

    // Decode select and status pins into a cycle kind; a low s1n means
    // a read, so a write is the one with s1n high and s0n low
    function automatic cycle_kind_t decode(input logic cod, input logic mio,
                                           input logic s1n, input logic s0n,
                                           input logic a1);
        if (!cod && !mio)
            decode = CYC_INTACK;
        else if (!cod && !s1n && !s0n)
            decode = a1 ? CYC_HALT : CYC_SHUTDOWN;
        else if (!cod)
            decode = s1n ? CYC_MEM_WR : CYC_MEM_RD;
        else if (!mio)
            decode = s1n ? CYC_IO_WR : CYC_IO_RD;
        else
            decode = CYC_CODE_RD;
    endfunction

    cstate_t            state_reg, state_next;
    logic               phase_reg, phase_next;     // Own divider copy
    logic [7:0]         wait_reg, wait_next;       // Wait proc cycles
    logic               ready_n_reg, ready_n_next;
    logic               doe_reg, doe_next;
    logic [`DATA_W-1:0] dout_reg, dout_next;
    logic               hreq_reg, hreq_next;
    logic               grant_reg, grant_next;
    logic               cv_reg, cv_next;
    cycle_kind_t        kind_reg, kind_next;
    logic [`ADDR_W-1:0] addr_reg, addr_next;
    logic [`DATA_W-1:0] wd_reg, wd_next;
    logic               up_reg, up_next;
    logic               tick;                      // Processor cycle end
    logic               in_status;

    assign tick = phase_reg;
    // Status state whenever either status line is low
    assign in_status = !(bus.status_hi_bus && bus.status_lo_bus);

    // Next values of the controller end
    always_comb begin
        state_next = state_reg;
        phase_next = ~phase_reg;
        wait_next = wait_reg;
        ready_n_next = ready_n_reg;
        doe_next = doe_reg;
        dout_next = dout_reg;
        hreq_next = hold_request;
        grant_next = bus.hold_grant;
        cv_next = 1'b0;
        kind_next = kind_reg;
        addr_next = addr_reg;
        wd_next = wd_reg;
        up_next = up_reg;
        if (tick) begin
            unique case (state_reg)
                C_IDLE: begin
                    if (in_status && !bus.hold_grant) begin
                        // Kind is latched while the status code stands
                        kind_next = decode(bus.code_or_intack_select,
                                           bus.mem_io_select,
                                           bus.status_hi_bus,
                                           bus.status_lo_bus,
                                           bus.cpu_addr[`HALT_BIT]);
                        addr_next = bus.cpu_addr;
                        up_next = !bus.upper_byte_enable_n;
                        wait_next = 8'(WAIT_STATES);
                        state_next = C_WAIT;
                    end
                end
                C_WAIT: begin
                    if (wait_reg == 8'h00) begin
                        ready_n_next = 1'b0;
                        doe_next = (kind_reg == CYC_MEM_RD) ||
                                   (kind_reg == CYC_CODE_RD) ||
                                   (kind_reg == CYC_IO_RD) ||
                                   (kind_reg == CYC_INTACK);
                        dout_next = read_data;
                        state_next = C_END;
                    end else begin
                        wait_next = wait_reg - 8'h01;
                    end
                end
                C_END: begin
                    wd_next = bus.data_bus;
                    cv_next = 1'b1;
                    ready_n_next = 1'b1;
                    doe_next = 1'b0;
                    state_next = C_IDLE;
                end
                default: state_next = C_IDLE;
            endcase
        end
    end

    // Controller registers; reset aligns the divider
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= C_IDLE;
            phase_reg <= 1'b0;
            wait_reg <= 8'h00;
            ready_n_reg <= 1'b1;
            doe_reg <= 1'b0;
            dout_reg <= '0;
            hreq_reg <= 1'b0;
            grant_reg <= 1'b0;
            cv_reg <= 1'b0;
            kind_reg <= CYC_INTACK;
            addr_reg <= '0;
            wd_reg <= '0;
            up_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            wait_reg <= wait_next;
            ready_n_reg <= ready_n_next;
            doe_reg <= doe_next;
            dout_reg <= dout_next;
            hreq_reg <= hreq_next;
            grant_reg <= grant_next;
            cv_reg <= cv_next;
            kind_reg <= kind_next;
            addr_reg <= addr_next;
            wd_reg <= wd_next;
            up_reg <= up_next;
        end
    end

    assign bus.ready_n = ready_n_reg;
    assign bus.ctrl_data_oe = doe_reg;
    assign bus.ctrl_data_out = dout_reg;
    assign bus.hold_req = hreq_reg;
    assign cyc_valid = cv_reg;
    assign cyc_kind = kind_reg;
    assign cyc_addr = addr_reg;
    assign cyc_wdata = wd_reg;
    assign upper_lane_sel = up_reg;
    assign hold_granted = grant_reg;

endmodule

// ===== testbench/bus_cycle_sva.sv
`timescale 1ns/100ps
`include "bus_cycle_defines.svh"
module bus_cycle_sva (
    input wire logic               core_clk,
    input wire logic               sys_rst,
    input wire logic               clk_en,
    input wire logic [`ADDR_W-1:0] cpu_addr,
    input wire logic               cpu_addr_oe,
    input wire logic               upper_byte_enable_n,
    input wire logic               cycle_status_hi_n,
    input wire logic               cycle_status_lo_n,
    input wire logic               status_oe,
    input wire logic               mem_io_select,
    input wire logic               code_or_intack_select,
    input wire logic               cpu_data_oe,
    input wire logic               ready_n,
    input wire logic               hold_grant,
    input wire logic               proc_phase
);
    // Status state: driven and at least one status line low
    logic       st;
    logic [3:0] code; // Select pair and status pair as one code
    assign st = status_oe && !(cycle_status_hi_n && cycle_status_lo_n);
    assign code = {code_or_intack_select, mem_io_select,
                   cycle_status_hi_n, cycle_status_lo_n};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_phase_halves: assert property (clk_en |=>
        proc_phase != $past(proc_phase)) else $error("phase not halved");
    a_phase_align: assert property ($fell(sys_rst) |->
        !proc_phase ##1 proc_phase) else $error("phase not aligned");
    a_write_drive: assert property ($rose(st) |-> ##2
        cpu_data_oe == $past(cycle_status_hi_n && !cycle_status_lo_n, 2))
        else $error("data direction wrong");
    a_hold_float: assert property (hold_grant |->
        !cpu_addr_oe && !status_oe && !cpu_data_oe)
        else $error("driver on in hold");
    a_io_upper_zero: assert property (st && !mem_io_select
        && code_or_intack_select |-> cpu_addr[23:16] == 8'h00)
        else $error("io upper address set");
    a_lane_legal: assert property (st |->
        !(upper_byte_enable_n && cpu_addr[0])) else $error("reserved lane");
    a_status_legal: assert property (st |-> !(code inside
        {4'h1, 4'h2, 4'h8, 4'hc, 4'he})) else $error("reserved status");
    a_status_width: assert property ($rose(st) |=> st ##1 !st)
        else $error("status width wrong");
    a_ready_ends: assert property ($fell(cpu_data_oe) |->
        !$past(ready_n)) else $error("cycle ended without ready");
    a_float_first: assert property ($rose(hold_grant) |->
        !$past(cpu_addr_oe)) else $error("grant before float");
    a_phase_frozen: assert property (!clk_en |=>
        $stable(proc_phase)) else $error("phase moved while frozen");
endmodule

// ===== testbench/tb.sv
`timescale 1ns/100ps
`include "bus_cycle_defines.svh"
module tb;
    import bus_cycle_pkg::*;
    logic               core_clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic               clk_en = 1'b1;  // Dropped once in mid-cycle
    logic               req_valid = 1'b0;
    cycle_kind_t        req_kind = CYC_MEM_RD;
    lane_t              req_lane = LANE_WORD;
    logic [`ADDR_W-1:0] req_addr = '0;
    logic [`DATA_W-1:0] req_wdata = '0;
    logic [`DATA_W-1:0] read_data = '0;
    logic               hold_request = 1'b0;
    logic               req_busy, req_done, cyc_valid, upper_lane_sel;
    logic               hold_granted;
    logic [`DATA_W-1:0] req_rdata, cyc_wdata, got_wdata;
    logic [`ADDR_W-1:0] cyc_addr, got_addr;
    cycle_kind_t        cyc_kind, got_kind;
    logic               got_up;
    int                 err_count = 0;
    int                 checked = 0;
    int                 cyc_count = 0;  // Cycles finished at the controller
    local_bus_if lb ();
    cpu_bus_end i_cpu_bus_end (.core_clk(core_clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .bus(lb), .req_valid(req_valid),
        .req_kind(req_kind), .req_lane(req_lane), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_busy(req_busy), .req_done(req_done),
        .req_rdata(req_rdata));
    bus_ctrl_end #(.WAIT_STATES(2)) i_bus_ctrl_end (.core_clk(core_clk),
        .sys_rst(sys_rst), .clk_en(clk_en), .bus(lb),
        .hold_request(hold_request), .read_data(read_data),
        .cyc_valid(cyc_valid), .cyc_kind(cyc_kind), .cyc_addr(cyc_addr),
        .cyc_wdata(cyc_wdata), .upper_lane_sel(upper_lane_sel),
        .hold_granted(hold_granted));
    bus_cycle_sva i_bus_cycle_sva (.core_clk(core_clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .cpu_addr(lb.cpu_addr),
        .cpu_addr_oe(lb.cpu_addr_oe),
        .upper_byte_enable_n(lb.upper_byte_enable_n),
        .cycle_status_hi_n(lb.cycle_status_hi_n),
        .cycle_status_lo_n(lb.cycle_status_lo_n),
        .status_oe(lb.status_oe), .mem_io_select(lb.mem_io_select),
        .code_or_intack_select(lb.code_or_intack_select),
        .cpu_data_oe(lb.cpu_data_oe), .ready_n(lb.ready_n),
        .hold_grant(lb.hold_grant), .proc_phase(lb.proc_phase));
    // 125 MHz core clock
    always #4 core_clk = ~core_clk;
    // Latch what the controller end decoded; its pulse lasts one cycle
    always @(posedge core_clk) begin
        if (cyc_valid === 1'b1) begin
            got_kind <= cyc_kind;
            got_addr <= cyc_addr;
            got_wdata <= cyc_wdata;
            got_up <= upper_lane_sel;
            cyc_count <= cyc_count + 1;
        end
    end
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Bounded stall: a hang counts as a mismatch and ends the run
    task automatic give_up(int n, int lim);
        if (n >= lim) begin
            err_count++;
            finish_test();
        end
    endtask
    // One whole cycle from request to done, judged at both ends
    task automatic do_cycle(cycle_kind_t k, lane_t ln, logic [23:0] a,
                            logic [15:0] wd, logic [15:0] rd);
        logic [23:0] ea;
        int n;
        int c0;
        ea = a;
        n = 0;
        c0 = cyc_count;
        req_kind = k;
        req_lane = ln;
        req_addr = a;
        req_wdata = wd;
        read_data = rd;
        req_valid = 1'b1;
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (req_done !== 1'b1 && n < 200);
        req_valid = 1'b0;  // Dropped within the done cycle
        give_up(n, 200);
        for (n = 0; cyc_count == c0 && n < 8; n++)
            @(posedge core_clk) #1;
        give_up(n, 8);
        if (k inside {CYC_IO_RD, CYC_IO_WR}) ea[23:16] = 8'h00;
        if (k == CYC_HALT) ea[1] = 1'b1;
        if (k == CYC_SHUTDOWN) ea[1] = 1'b0;
        check("kind", 32'(got_kind), 32'(k));
        check("addr", 32'(got_addr), 32'(ea));
        check("upper", 32'(got_up), 32'(ln != LANE_LO));
        if (k inside {CYC_MEM_WR, CYC_IO_WR})
            check("wdata", 32'(got_wdata), 32'(wd));
        if (k inside {CYC_INTACK, CYC_MEM_RD, CYC_CODE_RD, CYC_IO_RD})
            check("rdata", 32'(req_rdata), 32'(rd));
    endtask
    // Every kind back to back, lanes rotating
    task automatic all_kinds;
        lane_t ln;
        for (int k = 0; k < 8; k++) begin
            ln = lane_t'(k % 3);
            do_cycle(cycle_kind_t'(k), ln,
                     {8'hc3, 8'(k), 6'h2d, 1'b1, ln == LANE_HI},
                     16'h1e00 + 16'(k), 16'h9c30 ^ 16'(k));
        end
    endtask
    // Hold: drivers float, data keeps its level, requests wait
    task automatic hold_test;
        int n;
        hold_request = 1'b1;
        for (n = 0; hold_granted !== 1'b1 && n < 20; n++)
            @(posedge core_clk) #1;
        give_up(n, 20);
        check("addr_oe", 32'(lb.cpu_addr_oe), 32'h0);
        check("status", 32'({lb.status_hi_bus, lb.status_lo_bus}),
              32'h3);
        check("data", 32'(lb.data_bus), 32'h1e07);
        fork
            do_cycle(CYC_MEM_WR, LANE_WORD, 24'h0123a4, 16'h5aa5, 16'h0);
            begin
                repeat (6) @(posedge core_clk);
                #1 check("busy", 32'(req_busy), 32'h0);
                hold_request = 1'b0;
            end
        join
        check("grant", 32'(hold_granted), 32'h0);
    endtask
    // Enable low in the command phase: both ends stall, then finish
    task automatic freeze_test;
        fork
            do_cycle(CYC_IO_RD, LANE_LO, 24'hff5670, 16'h0, 16'h3cc3);
            begin
                // Past the status cycle, so its width is not stretched
                repeat (5) @(posedge core_clk);
                #1 clk_en = 1'b0;
                repeat (6) @(posedge core_clk);
                #1 check("stall", 32'(req_busy), 32'h1);
                clk_en = 1'b1;
            end
        join
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        all_kinds();
        hold_test();
        sys_rst = 1'b1;  // Second reset in mid-run
        repeat (2) @(posedge core_clk);
        #1 check("phase", 32'(lb.proc_phase), 32'h0);
        sys_rst = 1'b0;
        freeze_test();
        finish_test();
    end
endmodule
